// ===== shared/npr_defs.vh
// constants for the nonce, pause, random and read command engine
// Behaviour
// - nonce mode 0 mixes fresh random with input into temp key, seed refresh if needed
// - nonce mode 1 mixes random from existing seed with input, no seed update
// - nonce mode 3 loads temp key straight from input; mode 2 invalid
// - pause opcode 0x01, param1 selector, param2 zero, no data
// - pause with mismatched selector sends device idle, no response
// - pause with matching selector stays active, returns 0x00
// - pause never causes sleep, only idle
// - random opcode 0x1B, param2 zero, returns 32 random bytes
// - config unlocked makes random output pattern FF FF 00 00 repeated
// - seed update request after endurance limit returns an error
// - random mode bits 1-7 zero; bit 0 chooses refresh or keep seed
// - nonce and random share one stored seed
// - read opcode 0x02, zone bits 0-1, bits 2-6 zero, bit 7 means 32 bytes
// - address is word address; 32-byte reads ignore low three bits
// - read address beyond zone end returns error
// - config words always readable except never-readable bytes, which error
// - OTP read errors unlocked; locked, words 0-1 error if access mode nonzero
// - legacy OTP mode allows only 4-byte reads
// - data zone read errors while unlocked; slot policy governs after lock
// - secret slot with 4-byte read or without encrypted read errors
// - encrypted read XORs data with temp key; never for config or OTP
// - encrypted read needs key valid, digest flag, key slot match, random origin
// - pass-through needs 32-byte input, no hashing, no data, origin input
`ifndef NPR_DEFS_VH
`define NPR_DEFS_VH
`define NPR_OP_PAUSE    8'h01
`define NPR_OP_READ     8'h02
`define NPR_OP_NONCE    8'h16
`define NPR_OP_RANDOM   8'h1B
`define NPR_ZONE_CFG    2'h0
`define NPR_ZONE_OTP    2'h1
`define NPR_ZONE_DATA   2'h2
`define NPR_CFG_WORDS   7'h16
`define NPR_OTP_WORDS   7'h10
`define NPR_DATA_WORDS  7'h7F
`define NPR_ST_OK       8'h00
`define NPR_ST_PARSE    8'h03
`define NPR_ST_EXEC     8'h0F
`define NPR_OTP_LEGACY  8'hAA
`define NPR_TEST_WORD   32'h0000FFFF
`define NPR_NOTREAD_W   7'h05
// axi offsets
`define NPR_A_CMD       8'h00
`define NPR_A_ARGS      8'h04
`define NPR_A_STAT      8'h08
`define NPR_A_CFG       8'h0C
`define NPR_A_SLOT      8'h10
`define NPR_A_TKFLG     8'h14
`define NPR_A_RESP      8'h18
`define NPR_A_INPUT     8'h1C
`define NPR_A_MEM       8'h20
`define NPR_A_RAND      8'h24
`define NPR_A_SEEDCNT   8'h28
`define NPR_A_TKEY      8'h40
`define NPR_A_RBUF      8'h60
`endif

// ===== hdl/npr_cmd_engine.v
// command engine for nonce, pause, random and read over axi4-lite
`timescale 1ns/1ps
`include "npr_defs.vh"
module npr_cmd_engine #(
    parameter SEED_LIMIT = 16'hFFFF
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // axi write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // axi write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // axi write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // axi read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // device power state
    output reg         dev_idle
);
    // software-visible state
    reg  [31:0] cmd_word;     // opcode[7:0] param1[15:8] go written here
    reg  [15:0] param2;
    reg  [7:0]  status;
    reg  [7:0]  resp_len;
    reg  [7:0]  bus_selector_byte;
    reg  [7:0]  otp_access_mode;
    reg         cfg_locked;
    reg         otp_locked;
    reg         data_locked;
    reg  [15:0] slot_policy_word;
    reg         tk_valid;
    reg         digest_generated_flag;
    reg  [3:0]  key_slot_index;
    reg         key_origin_flag;  // 1 random, 0 input
    reg  [31:0] temp_key_reg [0:7];
    reg  [31:0] host_input_value [0:7];
    reg  [31:0] mem [0:127];
    reg  [31:0] rbuf [0:7];
    reg  [31:0] rng_state;
    reg  [31:0] seed;
    reg  [15:0] seed_writes;
    reg         busy;
    reg  [31:0] rd_data;
    reg         aw_hold;
    reg         w_hold;
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    integer     i;

    wire [7:0] op  = cmd_word[7:0];
    wire [7:0] p1  = cmd_word[15:8];
    wire       go  = cmd_word[31];
    wire [6:0] wa  = p1[7] ? {param2[6:3], 3'h0} : param2[6:0];

    // zone size in words
    function [6:0] zone_end;
        input [1:0] z;
        begin
            case (z)
                `NPR_ZONE_CFG:  zone_end = `NPR_CFG_WORDS;
                `NPR_ZONE_OTP:  zone_end = `NPR_OTP_WORDS;
                default:        zone_end = `NPR_DATA_WORDS;
            endcase
        end
    endfunction

    // permission check for a read, returns status
    reg [7:0] rd_chk;
    always @* begin
        rd_chk = `NPR_ST_OK;
        if (p1[6:2] != 5'h0 || p1[1:0] == 2'h3 || param2[15:7] != 9'h0)
            rd_chk = `NPR_ST_PARSE;
        else if ({1'b0, wa} + (p1[7] ? 8'h07 : 8'h00)
                 >= {1'b0, zone_end(p1[1:0])})
            rd_chk = `NPR_ST_EXEC;
        else if (p1[1:0] == `NPR_ZONE_CFG) begin
            if (wa <= `NPR_NOTREAD_W && wa + (p1[7] ? 7'h07 : 7'h00)
                >= `NPR_NOTREAD_W)
                rd_chk = `NPR_ST_EXEC;
        end else if (p1[1:0] == `NPR_ZONE_OTP) begin
            if (!otp_locked)
                rd_chk = `NPR_ST_EXEC;
            else if (otp_access_mode != 8'h00 && wa[6:1] == 6'h0)
                rd_chk = `NPR_ST_EXEC;
            else if (otp_access_mode == `NPR_OTP_LEGACY && p1[7])
                rd_chk = `NPR_ST_EXEC;
        end else begin
            if (!data_locked)
                rd_chk = `NPR_ST_EXEC;
            else if (slot_policy_word[7] && !p1[7])
                rd_chk = `NPR_ST_EXEC;
            else if (slot_policy_word[7] && !slot_policy_word[6])
                rd_chk = `NPR_ST_EXEC;
            else if (slot_policy_word[6] && !(tk_valid &&
                     digest_generated_flag && key_origin_flag &&
                     key_slot_index == slot_policy_word[3:0]))
                rd_chk = `NPR_ST_EXEC;
        end
    end

    // data zone xor only when encrypted; config and otp never
    wire enc = (p1[1:0] == `NPR_ZONE_DATA) && slot_policy_word[6];
    wire [6:0] base = (p1[1:0] == `NPR_ZONE_CFG) ? 7'h00 :
                      (p1[1:0] == `NPR_ZONE_OTP) ? 7'h16 : 7'h26;

    // random word source: test pattern until config lock
    wire [31:0] rnd_word = cfg_locked ? (rng_state ^ seed)
                                      : `NPR_TEST_WORD;

    // axi handshakes
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire do_wr = (aw_hold || s_axi_awvalid) && (w_hold || s_axi_wvalid)
                 && !s_axi_bvalid;
    wire [7:0]  wr_a = aw_hold ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_d = w_hold ? w_data : s_axi_wdata;

    // register read mux
    always @* begin
        rd_data = 32'h0;
        case (s_axi_araddr[7:2])
            6'h00: rd_data = {busy, 15'h0, cmd_word[15:0]};
            6'h01: rd_data = {16'h0, param2};
            6'h02: rd_data = {16'h0, resp_len, status};
            6'h03: rd_data = {13'h0, data_locked, otp_locked, cfg_locked,
                              otp_access_mode, bus_selector_byte};
            6'h04: rd_data = {16'h0, slot_policy_word};
            6'h05: rd_data = {24'h0, key_origin_flag, key_slot_index,
                              digest_generated_flag, tk_valid, dev_idle};
            6'h09: rd_data = rng_state;
            6'h0A: rd_data = {16'h0, seed_writes};
            default: begin
                if (s_axi_araddr[7:5] == 3'h2)
                    rd_data = temp_key_reg[s_axi_araddr[4:2]];
                else if (s_axi_araddr[7:5] == 3'h3)
                    rd_data = rbuf[s_axi_araddr[4:2]];
            end
        endcase
    end

    // axi write side and command engine
    always @(posedge clk) begin
        if (rst) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            cmd_word <= 32'h0;
            param2 <= 16'h0;
            status <= `NPR_ST_OK;
            resp_len <= 8'h00;
            bus_selector_byte <= 8'h00;
            otp_access_mode <= 8'h00;
            cfg_locked <= 1'b0;
            otp_locked <= 1'b0;
            data_locked <= 1'b0;
            slot_policy_word <= 16'h0;
            tk_valid <= 1'b0;
            digest_generated_flag <= 1'b0;
            key_slot_index <= 4'h0;
            key_origin_flag <= 1'b0;
            rng_state <= 32'h1;
            seed <= 32'h0;
            seed_writes <= 16'h0;
            busy <= 1'b0;
            dev_idle <= 1'b0;
        end else begin
            // free-running lfsr
            rng_state <= {rng_state[30:0], rng_state[31] ^ rng_state[21]
                          ^ rng_state[1] ^ rng_state[0]};
            if (s_axi_awvalid && s_axi_awready && !do_wr) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !do_wr) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (do_wr) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_a > 8'h7F) ? 2'h2 : 2'h0;
                case (wr_a[7:2])
                    6'h00: if (!busy) begin
                        cmd_word <= wr_d;
                        busy <= wr_d[31];
                        dev_idle <= 1'b0;   // any new command wakes it
                    end
                    6'h01: param2 <= wr_d[15:0];
                    6'h03: begin
                        bus_selector_byte <= wr_d[7:0];
                        otp_access_mode <= wr_d[15:8];
                        cfg_locked <= wr_d[16];
                        otp_locked <= wr_d[17];
                        data_locked <= wr_d[18];
                    end
                    6'h04: slot_policy_word <= wr_d[15:0];
                    6'h05: begin
                        digest_generated_flag <= wr_d[2];
                        key_slot_index <= wr_d[6:3];
                    end
                    6'h07: host_input_value[wr_d[31:29]] <=
                               {3'h0, wr_d[28:0]};
                    6'h08: mem[wr_d[30:24]] <= {8'h0, wr_d[23:0]};
                    default: begin
                        if (wr_a[7:5] == 3'h2 && !busy)
                            host_input_value[wr_a[4:2]] <= wr_d;
                    end
                endcase
            end
            // command execution
            if (busy) begin
                busy <= 1'b0;
                cmd_word[31] <= 1'b0;
                status <= `NPR_ST_OK;
                case (op)
                    `NPR_OP_PAUSE: begin
                        if (param2 != 16'h0) begin
                            status <= `NPR_ST_PARSE;
                            resp_len <= 8'h01;
                        end else if (p1 != bus_selector_byte) begin
                            dev_idle <= 1'b1;
                            resp_len <= 8'h00;
                        end else begin
                            resp_len <= 8'h01;
                        end
                    end
                    `NPR_OP_RANDOM, `NPR_OP_NONCE: begin
                        if (param2 != 16'h0 || (op == `NPR_OP_RANDOM ?
                            p1[7:1] != 7'h0 :
                            (p1[7:2] != 6'h0 || p1[1:0] == 2'h2))) begin
                            status <= `NPR_ST_PARSE;
                            resp_len <= 8'h01;
                        end else if (!p1[0] && !p1[1] &&
                                     seed_writes >= SEED_LIMIT) begin
                            status <= `NPR_ST_EXEC;
                            resp_len <= 8'h01;
                        end else if (op == `NPR_OP_NONCE && p1[1:0] == 2'h3)
                        begin
                            for (i = 0; i < 8; i = i + 1)
                                temp_key_reg[i] <= host_input_value[i];
                            tk_valid <= 1'b1;
                            key_origin_flag <= 1'b0;
                            digest_generated_flag <= 1'b0;
                            resp_len <= 8'h01;
                        end else begin
                            // shared seed refresh when mode bit 0 clear and config locked
                            if (!p1[0] && cfg_locked) begin
                                seed <= seed ^ rng_state;
                                seed_writes <= seed_writes + 16'h1;
                            end
                            for (i = 0; i < 8; i = i + 1) begin
                                rbuf[i] <= rnd_word ^
                                    (cfg_locked ? {i[7:0], 24'h0} : 32'h0);
                                if (op == `NPR_OP_NONCE)
                                    temp_key_reg[i] <= rnd_word ^
                                        host_input_value[i];
                            end
                            if (op == `NPR_OP_NONCE) begin
                                tk_valid <= 1'b1;
                                key_origin_flag <= 1'b1;
                                digest_generated_flag <= 1'b0;
                            end
                            resp_len <= 8'h20;
                        end
                    end
                    `NPR_OP_READ: begin
                        status <= rd_chk;
                        resp_len <= (rd_chk != `NPR_ST_OK) ? 8'h01 :
                                    (p1[7] ? 8'h20 : 8'h04);
                        for (i = 0; i < 8; i = i + 1)
                            rbuf[i] <= mem[base + wa + i[6:0]] ^
                                (enc ? temp_key_reg[i] : 32'h0);
                    end
                    default: begin
                        status <= `NPR_ST_PARSE;
                        resp_len <= 8'h01;
                    end
                endcase
            end
        end
    end

    // axi read channel
    always @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= (s_axi_araddr > 8'h7F) ? 2'h2 : 2'h0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // npr_cmd_engine

// ===== testbench/npr_cmd_engine_props.sv
// bus and idle-state checker for the command engine
`timescale 1ns/1ps
module npr_cmd_engine_props #(
    parameter SEED_LIMIT = 16'hFFFF
) (
    // clock and reset
    input wire        clk,
    input wire        rst,
    // write channels
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    // read channels
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // power state
    input wire        dev_idle
);
    // one clock domain, all checks quiet in reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    a_bvalid_ends: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("bvalid stuck");
    a_aw_blocked: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid && s_axi_bresp ==
        ($past(s_axi_awaddr) > 8'h7F ? 2'b10 : 2'b00)) else $error("bad b");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && s_axi_rresp ==
        ($past(s_axi_araddr) > 8'h7F ? 2'b10 : 2'b00)) else $error("bad r");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_rvalid_ends: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("rvalid stuck");
    a_idle_kept: assert property ((dev_idle && !s_axi_awvalid)[*4]
        |=> dev_idle) else $error("idle left without a write");
endmodule // npr_cmd_engine_props
bind npr_cmd_engine npr_cmd_engine_props #(.SEED_LIMIT(SEED_LIMIT)) chk_u (
    .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .dev_idle(dev_idle));

// ===== testbench/npr_axi_host.sv
// bus master model of the host controller
`timescale 1ns/1ps
module npr_axi_host (
    // clock
    input  wire        clk,
    // write channels
    output reg  [7:0]  awaddr,
    output reg         awvalid,
    input  wire        awready,
    output reg  [31:0] wdata,
    output reg         wvalid,
    input  wire        wready,
    input  wire        bvalid,
    output reg         bready,
    // read channels
    output reg  [7:0]  araddr,
    output reg         arvalid,
    input  wire        arready,
    input  wire [31:0] rdata,
    input  wire        rvalid,
    output reg         rready
);
    reg slow; // raise response ready only once the answer shows
    // idle bus at time zero
    initial begin
        slow = 1'b0;
        {awaddr, awvalid, wdata, wvalid, bready} = 43'h0;
        {araddr, arvalid, rready} = 10'h0;
    end
    // one write: address and data offered together, each dropped when taken
    task wr(input [7:0] ad, input [31:0] dt);
        reg ga, gw, gb;
        begin
            @(posedge clk);
            awaddr <= ad;
            wdata <= dt;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= !slow;
            {ga, gw, gb} = 3'h0;
            while (!(ga && gw)) begin
                @(posedge clk);
                if (awready && !ga) begin
                    ga = 1'b1;
                    awvalid <= 1'b0;
                end
                if (wready && !gw) begin
                    gw = 1'b1;
                    wvalid <= 1'b0;
                end
            end
            while (!gb) begin
                @(posedge clk);
                gb = bvalid && bready;
                if (bvalid)
                    bready <= 1'b1;
            end
            bready <= 1'b0;
        end
    endtask
    // one read: data taken at the edge where rvalid and rready meet
    task rd(input [7:0] ad, output [31:0] dt);
        reg gr;
        begin
            @(posedge clk);
            araddr <= ad;
            arvalid <= 1'b1;
            rready <= !slow;
            gr = 1'b0;
            while (!gr) begin
                @(posedge clk);
                if (arready)
                    arvalid <= 1'b0;
                gr = rvalid && rready;
                if (rvalid)
                    rready <= 1'b1;
            end
            dt = rdata;
            rready <= 1'b0;
        end
    endtask
endmodule // npr_axi_host

// ===== testbench/npr_cmd_engine_tb.sv
// self-checking bench for the command engine
`timescale 1ns/1ps
`include "npr_defs.vh"
`define NPR_CHK(n, e, s) begin \
    tests_run = tests_run + 1; \
    if ((s) !== (e)) begin \
        mismatches = mismatches + 1; \
        $display("BAD %s expected %h seen %h", n, e, s); \
    end \
end
module npr_cmd_engine_tb;
    // clock, reset, bus wires and bench state
    reg         clk;
    reg         rst;
    wire [7:0]  awaddr, araddr;
    wire [31:0] wdata, rdata;
    wire [1:0]  bresp, rresp;
    wire        awvalid, awready, wvalid, wready, bvalid, bready;
    wire        arvalid, arready, rvalid, rready, dev_idle;
    integer     mismatches;
    integer     tests_run;
    reg  [31:0] st, d, f;
    reg  [7:0]  a;
    npr_cmd_engine #(.SEED_LIMIT(16'h0003)) dut_u (
        .clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .dev_idle(dev_idle));
    npr_axi_host host_u (
        .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // run one command, poll busy, fetch status
    task run(input [7:0] op, input [7:0] p1, input [15:0] p2);
        begin
            host_u.wr(`NPR_A_ARGS, {16'h0000, p2});
            host_u.wr(`NPR_A_CMD, {1'b1, 15'h0000, p1, op});
            d = 32'h80000000;
            while (d[31] !== 1'b0)
                host_u.rd(`NPR_A_CMD, d);
            host_u.rd(`NPR_A_STAT, st);
            @(negedge clk);
        end
    endtask
    // status check, 8'hFF meaning any error code
    task chk_st(input [7:0] e);
        if (e == 8'hFF)
            `NPR_CHK("error", 1'b1, st[7:0] != 8'h00)
        else
            `NPR_CHK("status", e, st[7:0])
    endtask
    // read command with expected status
    task rc(input [7:0] p1, input [15:0] p2, input [7:0] e);
        begin
            run(`NPR_OP_READ, p1, p2);
            chk_st(e);
        end
    endtask
    // selector match and mismatch, bad second parameter
    task t_pause;
        begin
            `NPR_CHK("idle", 1'b0, dev_idle)
            host_u.wr(`NPR_A_CFG, 32'h0000005A);
            run(`NPR_OP_PAUSE, 8'h5A, 16'h0000);
            chk_st(8'h00);
            `NPR_CHK("len", 8'h01, st[15:8])
            `NPR_CHK("idle", 1'b0, dev_idle)
            run(`NPR_OP_PAUSE, 8'hA5, 16'h0000);
            `NPR_CHK("idle", 1'b1, dev_idle)
            `NPR_CHK("len", 8'h00, st[15:8])
            run(`NPR_OP_PAUSE, 8'h5A, 16'h0100);
            chk_st(`NPR_ST_PARSE);
            `NPR_CHK("idle", 1'b0, dev_idle)
        end
    endtask
    // test pattern while unlocked, bad mode, refused addresses
    task t_random;
        begin
            run(`NPR_OP_RANDOM, 8'h00, 16'h0000);
            `NPR_CHK("len", 8'h20, st[15:8])
            for (a = `NPR_A_RBUF; a < 8'h80; a = a + 8'h04) begin
                host_u.rd(a, d);
                `NPR_CHK("rand", `NPR_TEST_WORD, d)
            end
            run(`NPR_OP_RANDOM, 8'h02, 16'h0000);
            chk_st(`NPR_ST_PARSE);
            host_u.slow = 1'b1;
            host_u.wr(8'h80, 32'h00000000);
            host_u.rd(8'hFC, d);
            host_u.slow = 1'b0;
        end
    endtask
    // pass-through, mixing mode, invalid mode
    task t_nonce;
        begin
            for (a = `NPR_A_TKEY; a < `NPR_A_RBUF; a = a + 8'h04)
                host_u.wr(a, {8'hC3, a, 16'h5AA5});
            run(`NPR_OP_NONCE, 8'h03, 16'h0000);
            chk_st(8'h00);
            `NPR_CHK("len", 8'h01, st[15:8])
            for (a = `NPR_A_TKEY; a < `NPR_A_RBUF; a = a + 8'h04) begin
                host_u.rd(a, d);
                `NPR_CHK("key", {8'hC3, a, 16'h5AA5}, d)
            end
            host_u.rd(`NPR_A_TKFLG, f);
            for (a = `NPR_A_TKEY; a < 8'h54; a = a + 8'h04)
                host_u.wr(a, {8'h3C, a, 16'hA55A});
            run(`NPR_OP_NONCE, 8'h00, 16'h0000);
            chk_st(8'h00);
            host_u.rd(`NPR_A_TKEY, st);
            `NPR_CHK("mix", `NPR_TEST_WORD ^ 32'h3C40A55A, st)
            host_u.rd(`NPR_A_TKFLG, d);
            `NPR_CHK("valid", 1'b1, d[1])
            `NPR_CHK("origin", 1'b1, d[7] != f[7])
            run(`NPR_OP_NONCE, 8'h02, 16'h0000);
            chk_st(`NPR_ST_PARSE);
        end
    endtask
    // seed kept by mode 1, worn out by mode 0, shared by both commands
    task t_seed;
        begin
            host_u.wr(`NPR_A_CFG, 32'h0001005A);
            host_u.rd(`NPR_A_SEEDCNT, f);
            run(`NPR_OP_RANDOM, 8'h01, 16'h0000);
            host_u.rd(`NPR_A_SEEDCNT, d);
            `NPR_CHK("seed", f, d)
            repeat (5) run(`NPR_OP_RANDOM, 8'h00, 16'h0000);
            chk_st(8'hFF);
            host_u.rd(`NPR_A_SEEDCNT, d);
            `NPR_CHK("seed", 32'h00000003, d)
            run(`NPR_OP_NONCE, 8'h00, 16'h0000);
            chk_st(8'hFF);
            run(`NPR_OP_NONCE, 8'h01, 16'h0000);
            chk_st(8'h00);
        end
    endtask
    // zone, lock, mode and slot policy cases of the read command
    task t_read;
        begin
            rc(8'h00, 16'h0000, 8'h00);
            `NPR_CHK("len", 8'h04, st[15:8])
            rc(8'h80, 16'h000B, 8'h00);
            `NPR_CHK("len", 8'h20, st[15:8])
            rc(8'h00, 16'h0005, 8'hFF);
            rc(8'h00, 16'h0016, 8'hFF);
            rc(8'h04, 16'h0000, `NPR_ST_PARSE);
            rc(8'h01, 16'h0002, 8'hFF);
            rc(8'h02, 16'h0000, 8'hFF);
            host_u.wr(`NPR_A_CFG, 32'h0007005A);
            rc(8'h01, 16'h0000, 8'h00);
            rc(8'h01, 16'h0010, 8'hFF);
            host_u.wr(`NPR_A_CFG, 32'h0007AA5A);
            rc(8'h01, 16'h0001, 8'hFF);
            rc(8'h81, 16'h0008, 8'hFF);
            rc(8'h01, 16'h0002, 8'h00);
            host_u.wr(`NPR_A_MEM, 32'h26123456);
            host_u.wr(`NPR_A_SLOT, 32'h00000000);
            rc(8'h02, 16'h0000, 8'h00);
            host_u.rd(`NPR_A_RBUF, d);
            `NPR_CHK("plain", 32'h00123456, d)
            host_u.wr(`NPR_A_SLOT, 32'h00000080);
            rc(8'h02, 16'h0000, 8'hFF);
            rc(8'h82, 16'h0000, 8'hFF);
            host_u.wr(`NPR_A_SLOT, 32'h000000C5);
            host_u.wr(`NPR_A_TKFLG, 32'h00000028);
            rc(8'h82, 16'h0000, 8'hFF);
            host_u.wr(`NPR_A_TKFLG, 32'h00000034);
            rc(8'h82, 16'h0000, 8'hFF);
            host_u.wr(`NPR_A_TKFLG, 32'h0000002C);
            rc(8'h82, 16'h0000, 8'h00);
            host_u.rd(`NPR_A_TKEY, f);
            host_u.rd(`NPR_A_RBUF, d);
            `NPR_CHK("crypt", f ^ 32'h00123456, d)
        end
    endtask
    // verdict and end of run
    task test_done;
        begin
            if (mismatches == 0 && tests_run > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // reset, then the scenarios in order
    initial begin
        mismatches = 0;
        tests_run = 0;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_pause;
        t_random;
        t_nonce;
        t_seed;
        t_read;
        test_done;
    end
    // watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge clk);
        mismatches = mismatches + 1;
        test_done;
    end
endmodule // npr_cmd_engine_tb
